/* eba_endpoint_buffer_access.sv */
// endpoint buffer access: command decode, buffer pointer, status words, read buffer
// How it works
// - Buffer commands reset the pointer to word zero; each word before the last advances it by two.
// - DMA accesses skip the length word and start at word one.
// - Reads mark the final packet word from the stored packet length.
// - Outside DMA, bulk and interrupt IN buffers are sent only once completely filled.
// - Transfer end input during DMA write sends the buffer, full or not.
// - Codes 01 to 0F are buffer writes for endpoint indices one to fifteen.
// - Code 10 reads control OUT; codes 12 to 1F read endpoint indices two to fifteen.
// - Word zero holds packet length; later words hold two bytes, earlier byte low.
// - Select high carries a command in the low byte; select low carries data words.
// - DMA on a double-buffered endpoint wraps from primary into secondary buffer.
// - Codes 50 to 5F read one status word per endpoint index.
// - Reading a status word clears that endpoint's interrupt flag.
// - Bit 7 stall: set by stall, cleared by unstall or a SETUP token.
// - Bit 6 shows secondary buffer full, bit 5 primary buffer full.
// - Bit 4 shows the data toggle of the next packet.
// - Bit 3 flags a replaced setup; a read clears it once setup writing ended.
// - Bit 2 marks a held setup, bit 1 the cpu buffer, bit 0 reserved.
`timescale 1ns/100ps
`default_nettype none
module eba_endpoint_buffer_access #(
	parameter int BUF_BYTES = eba_pkg::BUF_BYTES_DEF,
	parameter logic [15:0] DOUBLE_MASK = 16'h0000,
	parameter logic [15:0] ISO_MASK = 16'h0000,
	localparam int WORDS = (BUF_BYTES + 1) / 2 + 1,
	localparam int PW = $clog2(WORDS),
	localparam int AW = 5 + PW
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// parallel command and data port
	input wire logic busWrite,
	input wire logic busRead,
	input wire logic commandDataSelect,
	input wire logic [15:0] busDataIn,
	input wire logic dmaMode,
	input wire logic transferEndInput,
	output logic busReady,
	// read word buffer
	output logic [15:0] readData,
	output logic readLast,
	output logic readValid,
	input wire logic readReady,
	// usb engine events
	input wire logic usbEvent,
	input wire logic [3:0] usbEventEp,
	input wire logic usbEventBuf,
	input wire logic usbSetup,
	input wire logic usbFilled,
	input wire logic usbSent,
	input wire logic usbToggle,
	input wire logic usbSetupBusy,
	// usb engine buffer port
	input wire logic usbWrEn,
	input wire logic [AW-1:0] usbAddr,
	input wire logic [15:0] usbWrData,
	output logic [15:0] usbRdData,
	// send request to usb engine
	output logic sendValid,
	output logic [3:0] sendEp,
	output logic sendBuf,
	output logic [15:0] sendLen,
	// interrupt flag clear
	output logic intClear,
	output logic [3:0] intClearEp
);
	localparam int BPW = PW + 1;
	localparam logic [PW-1:0] LAST_IDX = PW'(WORDS - 1);
	logic [15:0] bufMem [0:(1 << AW) - 1];
	eba_pkg::eba_mode_t modeReg;
	logic [3:0] epReg;
	logic bufSelReg;
	logic dmaReg;
	logic [BPW-1:0] bytePtrReg;
	logic [15:0] lenReg;
	logic [15:0] stallReg, full0Reg, full1Reg, toggleReg, replacedReg, setupReg, cpuBufReg;
	logic headV, tailV, headL, tailL;
	logic [15:0] headD, tailD;
	function automatic logic [7:0] statusOf(input logic [3:0] e);
		logic [7:0] s;
		s = eba_pkg::STAT_RESET;
		s[eba_pkg::ST_STALL] = stallReg[e];
		s[eba_pkg::ST_FULL1] = full1Reg[e];
		s[eba_pkg::ST_FULL0] = full0Reg[e];
		s[eba_pkg::ST_TOGGLE] = toggleReg[e];
		s[eba_pkg::ST_REPLACED] = replacedReg[e];
		s[eba_pkg::ST_SETUP] = setupReg[e];
		s[eba_pkg::ST_CPU_BUFFER_SELECT] = cpuBufReg[e];
		return s;
	endfunction : statusOf
	wire logic [7:0] code = busDataIn[7:0];
	wire logic [3:0] codeEp = busDataIn[3:0];
	wire logic cmdTake = busWrite && commandDataSelect && busReady;
	wire logic isWrCmd = code >= eba_pkg::CMD_WR_FIRST && code <= eba_pkg::CMD_WR_LAST;
	wire logic isRdCmd = code == eba_pkg::CMD_RD_CTRL || (code >= eba_pkg::CMD_RD_FIRST && code <= eba_pkg::CMD_RD_LAST);
	wire logic statTake = cmdTake && code[7:4] == eba_pkg::CMD_STATUS;
	wire logic stallCmd = cmdTake && code[7:4] == eba_pkg::CMD_STALL;
	wire logic unstallCmd = cmdTake && code[7:4] == eba_pkg::CMD_UNSTALL;
	wire logic bufCmd = cmdTake && (isWrCmd || isRdCmd);
	wire logic dataWr = busWrite && !commandDataSelect && busReady && modeReg == eba_pkg::MODE_WRITE;
	wire logic dataRd = busRead && !commandDataSelect && busReady && modeReg == eba_pkg::MODE_READ;
	wire logic [PW-1:0] wordIdx = bytePtrReg[BPW-1:1];
	wire logic [AW-1:0] memAddr = {epReg, bufSelReg, wordIdx};
	wire logic endOfBuf = wordIdx == LAST_IDX;
	wire logic dmaWrap = dmaReg && DOUBLE_MASK[epReg] && !bufSelReg && endOfBuf && (dataWr || dataRd);
	wire logic fillDone = dataWr && endOfBuf && !ISO_MASK[epReg];
	wire logic eotSend = transferEndInput && dmaReg && modeReg == eba_pkg::MODE_WRITE;
	wire logic sendNow = fillDone || eotSend;
	// last data word index from packet length in bytes
	wire logic [15:0] lenWords = 16'((17'(lenReg) + 17'h00001) >> 1);
	wire logic pushLast = dataRd && 16'(wordIdx) == lenWords;
	wire logic push = statTake || dataRd;
	wire logic [15:0] pushData = statTake ? {8'h00, statusOf(codeEp)} : bufMem[memAddr];
	wire logic pop = headV && readReady;
	wire logic [1:0] occNext = 2'({1'b0, headV} + {1'b0, tailV} + {1'b0, push} - {1'b0, pop});
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// transfer mode and endpoint
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			modeReg <= eba_pkg::MODE_IDLE;
			epReg <= 4'h0;
			dmaReg <= 1'b0;
		end else if (cmdTake) begin
			if (isWrCmd)
				modeReg <= eba_pkg::MODE_WRITE;
			else if (isRdCmd)
				modeReg <= eba_pkg::MODE_READ;
			else
				modeReg <= eba_pkg::MODE_IDLE;
			epReg <= codeEp;
			dmaReg <= dmaMode;
		end else if (eotSend) begin
			modeReg <= eba_pkg::MODE_IDLE;
		end
	end
	chk_write_decode: assert property (cmdTake && isWrCmd |=> modeReg == eba_pkg::MODE_WRITE && epReg == $past(codeEp))
		else $error("write command not decoded");
	chk_read_decode: assert property (cmdTake && isRdCmd |=> modeReg == eba_pkg::MODE_READ && epReg == $past(codeEp))
		else $error("read command not decoded");
	// buffer pointer and buffer select
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bytePtrReg <= '0;
			bufSelReg <= 1'b0;
		end else if (bufCmd) begin
			// dma starts past the length word
			bytePtrReg <= dmaMode ? BPW'(eba_pkg::PTR_DMA_START) : '0;
			bufSelReg <= cpuBufReg[codeEp];
		end else if (dmaWrap) begin
			bytePtrReg <= BPW'(eba_pkg::PTR_DMA_START);
			bufSelReg <= 1'b1;
		end else if ((dataWr || dataRd) && !endOfBuf) begin
			bytePtrReg <= bytePtrReg + BPW'(eba_pkg::PTR_STEP);
		end
	end
	chk_ptr_start: assert property (bufCmd && !dmaMode |=> bytePtrReg == '0)
		else $error("pointer not at buffer start");
	chk_ptr_step: assert property ((dataWr || dataRd) && !endOfBuf && !dmaWrap |=> bytePtrReg == $past(bytePtrReg) + 2)
		else $error("pointer did not step by two");
	chk_dma_skip: assert property (bufCmd && dmaMode |=> bytePtrReg == 2 && wordIdx == 1)
		else $error("dma did not skip length word");
	chk_dma_wrap: assert property (dmaWrap |=> bufSelReg && bytePtrReg == 2)
		else $error("dma did not wrap to secondary");
	// packet length capture
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			lenReg <= 16'h0000;
		else if (cmdTake && isRdCmd)
			lenReg <= bufMem[{codeEp, cpuBufReg[codeEp], PW'(0)}];
		// word zero written is the length
		else if (dataWr && wordIdx == '0)
			lenReg <= busDataIn;
	end
	// buffer memory, cpu and usb ports
	always_ff @(posedge clk) begin
		if (dataWr)
			bufMem[memAddr] <= busDataIn;
		if (usbWrEn)
			bufMem[usbAddr] <= usbWrData;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			usbRdData <= 16'h0000;
		else
			usbRdData <= bufMem[usbAddr];
	end
	// send request to usb engine
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sendValid <= 1'b0;
			sendEp <= 4'h0;
			sendBuf <= 1'b0;
			sendLen <= 16'h0000;
		end else begin
			// send on full buffer, or on dma end
			sendValid <= sendNow;
			if (sendNow) begin
				sendEp <= epReg;
				sendBuf <= bufSelReg;
				if (!dmaReg)
					sendLen <= lenReg;
				else if (fillDone)
					sendLen <= 16'(bytePtrReg);
				else
					sendLen <= 16'(bytePtrReg - BPW'(eba_pkg::PTR_DMA_START));
			end
		end
	end
	chk_fill_send: assert property (fillDone |=> sendValid && sendBuf == $past(bufSelReg))
		else $error("filled buffer not sent");
	chk_eot_send: assert property (eotSend |=> sendValid && modeReg == eba_pkg::MODE_IDLE)
		else $error("transfer end did not send");
	// interrupt flag clear on status read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			intClear <= 1'b0;
			intClearEp <= 4'h0;
		end else begin
			intClear <= statTake;
			if (statTake)
				intClearEp <= codeEp;
		end
	end
	chk_status_clear: assert property (statTake |=> intClear && intClearEp == $past(codeEp))
		else $error("status read did not clear flag");
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stallReg <= 16'h0000;
			setupReg <= 16'h0000;
			toggleReg <= 16'h0000;
			replacedReg <= 16'h0000;
			full0Reg <= 16'h0000;
			full1Reg <= 16'h0000;
			cpuBufReg <= 16'h0000;
		end else begin
			for (int e = 0; e < 16; e++) begin
				// stall set, unstall and setup clear
				if (stallCmd && codeEp == 4'(e))
					stallReg[e] <= 1'b1;
				else if ((usbEvent && usbSetup && usbEventEp == 4'(e)) || (unstallCmd && codeEp == 4'(e)))
					stallReg[e] <= 1'b0;
				if (usbEvent && usbSetup && usbEventEp == 4'(e))
					setupReg[e] <= 1'b1;
				else if (stallCmd && codeEp == 4'(e))
					setupReg[e] <= 1'b0;
				if (usbEvent && usbToggle && usbEventEp == 4'(e))
					toggleReg[e] <= !toggleReg[e];
				if (usbEvent && usbSetup && usbEventEp == 4'(e) && setupReg[e])
					replacedReg[e] <= 1'b1;
				else if (statTake && codeEp == 4'(e) && !usbSetupBusy)
					replacedReg[e] <= 1'b0;
				if ((sendNow && epReg == 4'(e) && !bufSelReg) || (usbEvent && usbFilled && usbEventEp == 4'(e) && !usbEventBuf))
					full0Reg[e] <= 1'b1;
				else if (usbEvent && usbSent && usbEventEp == 4'(e) && !usbEventBuf)
					full0Reg[e] <= 1'b0;
				if ((sendNow && epReg == 4'(e) && bufSelReg) || (usbEvent && usbFilled && usbEventEp == 4'(e) && usbEventBuf))
					full1Reg[e] <= 1'b1;
				else if (usbEvent && usbSent && usbEventEp == 4'(e) && usbEventBuf)
					full1Reg[e] <= 1'b0;
				// cpu buffer select flips on double-buffered switch
				if (DOUBLE_MASK[e] && epReg == 4'(e) && (sendNow || dmaWrap))
					cpuBufReg[e] <= !cpuBufReg[e];
			end
		end
	end
	chk_stall_setup: assert property (usbEvent && usbSetup && !(stallCmd && codeEp == usbEventEp) |=> !stallReg[$past(usbEventEp)])
		else $error("setup token did not clear stall");
	// two-entry read buffer, status and buffer words
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			headV <= 1'b0;
			tailV <= 1'b0;
			headD <= 16'h0000;
			tailD <= 16'h0000;
			headL <= 1'b0;
			tailL <= 1'b0;
			busReady <= 1'b1;
		end else begin
			busReady <= occNext < 2'd2;
			if (pop) begin
				if (tailV) begin
					headD <= tailD;
					headL <= tailL;
					tailV <= push;
					tailD <= pushData;
					tailL <= pushLast;
				end else begin
					headV <= push;
					headD <= pushData;
					headL <= pushLast;
				end
			end else if (push) begin
				if (!headV) begin
					headV <= 1'b1;
					headD <= pushData;
					headL <= pushLast;
				end else begin
					tailV <= 1'b1;
					tailD <= pushData;
					tailL <= pushLast;
				end
			end
		end
	end
	assign readData = headD;
	assign readLast = headL;
	assign readValid = headV;
	chk_status_word: assert property (statTake && !headV |=> readValid && readData == {8'h00, $past(statusOf(codeEp))})
		else $error("status word not returned");
	chk_read_last: assert property (dataRd && pushLast && !headV |=> readValid && readLast)
		else $error("last packet word not marked");
endmodule : eba_endpoint_buffer_access
`default_nettype wire

/* eba_pkg.sv */
// shared constants for the endpoint buffer access block
package eba_pkg;
	// default endpoint buffer size in bytes
	localparam int BUF_BYTES_DEF = 32;
	// byte step of the buffer pointer per word
	localparam int PTR_STEP = 2;
	// first byte position when dma skips the length word
	localparam int PTR_DMA_START = 2;
	// command codes
	localparam logic [7:0] CMD_WR_FIRST = 8'h01;
	localparam logic [7:0] CMD_WR_LAST = 8'h0f;
	localparam logic [7:0] CMD_RD_CTRL = 8'h10;
	localparam logic [7:0] CMD_RD_FIRST = 8'h12;
	localparam logic [7:0] CMD_RD_LAST = 8'h1f;
	localparam logic [3:0] CMD_STATUS = 4'h5;
	localparam logic [3:0] CMD_STALL = 4'h4;
	localparam logic [3:0] CMD_UNSTALL = 4'h8;
	// endpoint_status field positions and reset value
	localparam int ST_STALL = 7;
	localparam int ST_FULL1 = 6;
	localparam int ST_FULL0 = 5;
	localparam int ST_TOGGLE = 4;
	localparam int ST_REPLACED = 3;
	localparam int ST_SETUP = 2;
	localparam int ST_CPU_BUFFER_SELECT = 1;
	localparam logic [7:0] STAT_RESET = 8'h00;
	typedef enum logic [1:0] {
		MODE_IDLE,
		MODE_WRITE,
		MODE_READ
	} eba_mode_t;
endpackage : eba_pkg

/* eba_host_model.sv */
// host processor model driving the command and data port
`timescale 1ns/100ps
`default_nettype none
module eba_host_model (
	// clock and ready
	input wire logic clk,
	input wire logic busReady,
	// bus drive
	output logic busWrite,
	output logic busRead,
	output logic commandDataSelect,
	output logic [15:0] busDataIn,
	output logic dmaMode,
	output logic transferEndInput
);
	initial begin
		busWrite = 1'b0;
		busRead = 1'b0;
		commandDataSelect = 1'b0;
		busDataIn = 16'h0000;
		dmaMode = 1'b0;
		transferEndInput = 1'b0;
	end
	task automatic access(input logic wr, input logic sel, input logic [15:0] d);
		logic r;
		r = 1'b0;
		repeat ($urandom % 3) @(posedge clk);
		@(posedge clk);
		busWrite <= wr;
		busRead <= !wr;
		commandDataSelect <= sel;
		busDataIn <= d;
		while (!r) begin
			@(negedge clk);
			r = (busReady === 1'b1);
			@(posedge clk);
		end
		busWrite <= 1'b0;
		busRead <= 1'b0;
		// released data lines never keep the last word
		busDataIn <= ~d;
	endtask : access
	task automatic setDma(input logic m);
		@(posedge clk);
		dmaMode <= m;
	endtask : setDma
	task automatic endPulse();
		@(posedge clk);
		transferEndInput <= 1'b1;
		@(posedge clk);
		transferEndInput <= 1'b0;
	endtask : endPulse
endmodule : eba_host_model
`default_nettype wire

/* eba_endpoint_buffer_access_bench.sv */
// testbench with reference model for the endpoint buffer access block
`timescale 1ns/100ps
`default_nettype none
module eba_endpoint_buffer_access_bench;
	logic clk = 1'b0, reset_n = 1'b0, readReady = 1'b0, stallOn = 1'b0;
	logic usbEvent = 1'b0, usbEventBuf = 1'b0, usbSetup = 1'b0, usbFilled = 1'b0;
	logic usbSent = 1'b0, usbToggle = 1'b0, usbSetupBusy = 1'b0, usbWrEn = 1'b0;
	logic [3:0] usbEventEp = 4'h0;
	logic [9:0] usbAddr = 10'h000;
	logic [15:0] usbWrData = 16'h0000;
	logic busWrite, busRead, commandDataSelect, dmaMode, transferEndInput, busReady;
	logic readLast, readValid, sendValid, sendBuf, intClear;
	logic [15:0] busDataIn, readData, usbRdData, sendLen, len, m;
	logic [3:0] sendEp, intClearEp, ep;
	logic [17:0] e;
	logic [15:0] mem [16][2][17];
	logic [7:0] st [16];
	logic [17:0] rdQ[$];
	logic [3:0] clrQ[$];
	logic [20:0] sndQ[$];
	logic [7:0] rdCodes [3] = '{8'h10, 8'h13, 8'h1f};
	int fail_count = 0, n_checks = 0;
	always #5 clk = ~clk;
	eba_host_model eba_host_model_inst (.clk(clk), .busReady(busReady), .busWrite(busWrite), .busRead(busRead),
		.commandDataSelect(commandDataSelect), .busDataIn(busDataIn), .dmaMode(dmaMode),
		.transferEndInput(transferEndInput));
	eba_endpoint_buffer_access #(.BUF_BYTES(32), .DOUBLE_MASK(16'h8000), .ISO_MASK(16'h0000))
	eba_endpoint_buffer_access_inst (.clk(clk), .reset_n(reset_n), .busWrite(busWrite), .busRead(busRead),
		.commandDataSelect(commandDataSelect), .busDataIn(busDataIn), .dmaMode(dmaMode),
		.transferEndInput(transferEndInput), .busReady(busReady), .readData(readData), .readLast(readLast),
		.readValid(readValid), .readReady(readReady), .usbEvent(usbEvent), .usbEventEp(usbEventEp),
		.usbEventBuf(usbEventBuf), .usbSetup(usbSetup), .usbFilled(usbFilled), .usbSent(usbSent),
		.usbToggle(usbToggle), .usbSetupBusy(usbSetupBusy), .usbWrEn(usbWrEn), .usbAddr(usbAddr),
		.usbWrData(usbWrData), .usbRdData(usbRdData), .sendValid(sendValid), .sendEp(sendEp),
		.sendBuf(sendBuf), .sendLen(sendLen), .intClear(intClear), .intClearEp(intClearEp));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	// upper byte of a command is random, it must be ignored
	task automatic cmd(input logic [7:0] code);
		eba_host_model_inst.access(1'b1, 1'b1, {8'($urandom), code});
	endtask : cmd
	task automatic stat(input logic [3:0] i);
		clrQ.push_back(i);
		rdQ.push_back({2'b00, 8'h00, st[i]});
		cmd({4'h5, i});
		if (!usbSetupBusy)
			st[i][3] = 1'b0;
	endtask : stat
	task automatic ev(input logic [3:0] i, input logic b, input int k);
		@(posedge clk);
		usbEvent <= 1'b1;
		usbEventEp <= i;
		usbEventBuf <= b;
		usbSetup <= (k == 0);
		usbFilled <= (k == 1);
		usbSent <= (k == 2);
		usbToggle <= (k == 3);
		@(posedge clk);
		usbEvent <= 1'b0;
		if (k == 0) begin
			st[i][3] = st[i][3] | st[i][2];
			st[i][2] = 1'b1;
			st[i][7] = 1'b0;
		end
		if (k == 1 || k == 2)
			st[i][5 + b] = (k == 1);
		if (k == 3)
			st[i][4] = ~st[i][4];
	endtask : ev
	task automatic poke(input logic [3:0] i, input logic b, input int w, input logic [15:0] d);
		@(posedge clk);
		usbWrEn <= 1'b1;
		usbAddr <= {i, b, 5'(w)};
		usbWrData <= d;
		@(posedge clk);
		usbWrEn <= 1'b0;
		mem[i][b][w] = d;
	endtask : poke
	task automatic peek(input logic [3:0] i, input logic b, input int w);
		@(posedge clk);
		usbAddr <= {i, b, 5'(w)};
		@(posedge clk);
		#1 chk(usbRdData, mem[i][b][w]);
	endtask : peek
	always @(posedge clk) begin
		readReady <= stallOn ? ($urandom % 4 == 0) : 1'b1;
		if (readValid === 1'b1 && readReady === 1'b1) begin
			e = rdQ.pop_front();
			chk(readData, e[15:0]);
			if (e[17])
				chk(readLast, e[16]);
		end
		if (intClear === 1'b1)
			chk(intClearEp, clrQ.pop_front());
		if (sendValid === 1'b1)
			chk({sendEp, sendBuf, sendLen}, sndQ.pop_front());
	end
	initial begin
		#500000;
		fail_count++;
		test_done();
	end
	initial begin
		void'($urandom(30472));
		foreach (st[i])
			st[i] = 8'h00;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 16; i++)
			stat(4'(i));
		$display("test reset status done");
		for (int c = 1; c < 15; c++) begin
			len = 16'($urandom % 33);
			mem[c][0][0] = len;
			for (int w = 1; w < 17; w++)
				mem[c][0][w] = 16'($urandom);
			sndQ.push_back({4'(c), 1'b0, len});
			st[c][5] = 1'b1;
			cmd(8'(c));
			for (int w = 0; w < 17; w++)
				eba_host_model_inst.access(1'b1, 1'b0, mem[c][0][w]);
			for (int w = 0; w < 17; w++)
				peek(4'(c), 1'b0, w);
		end
		$display("test buffer writes done");
		stallOn = 1'b1;
		foreach (rdCodes[i]) begin
			ep = rdCodes[i][3:0];
			len = 16'($urandom % 33);
			m = (len + 16'h0001) / 16'h0002;
			poke(ep, 1'b0, 0, len);
			for (int w = 1; w <= m; w++)
				poke(ep, 1'b0, w, 16'($urandom));
			cmd(rdCodes[i]);
			// exactly m plus one words
			for (int w = 0; w <= m; w++) begin
				rdQ.push_back({1'b1, w == m, mem[ep][0][w]});
				eba_host_model_inst.access(1'b0, 1'b0, 16'(w));
			end
		end
		repeat (20) @(posedge clk);
		stallOn = 1'b0;
		$display("test buffer reads done");
		usbSetupBusy <= 1'b1;
		ev(4'h0, 1'b0, 0);
		ev(4'h0, 1'b0, 0);
		stat(4'h0);
		@(posedge clk);
		usbSetupBusy <= 1'b0;
		stat(4'h0);
		// firmware rereads after a replaced setup
		stat(4'h0);
		cmd(8'h45);
		st[5][7] = 1'b1;
		st[5][2] = 1'b0;
		stat(4'h5);
		cmd(8'h85);
		st[5][7] = 1'b0;
		stat(4'h5);
		cmd(8'h45);
		st[5][7] = 1'b1;
		ev(4'h5, 1'b0, 0);
		stat(4'h5);
		ev(4'h5, 1'b0, 3);
		ev(4'h5, 1'b1, 1);
		stat(4'h5);
		ev(4'h5, 1'b1, 2);
		stat(4'h5);
		$display("test status bits done");
		eba_host_model_inst.setDma(1'b1);
		cmd(8'h04);
		for (int w = 1; w < 4; w++) begin
			mem[4][0][w] = 16'($urandom);
			eba_host_model_inst.access(1'b1, 1'b0, mem[4][0][w]);
		end
		sndQ.push_back({4'h4, 1'b0, 16'h0006});
		eba_host_model_inst.endPulse();
		for (int w = 1; w < 4; w++)
			peek(4'h4, 1'b0, w);
		cmd(8'h0f);
		for (int w = 1; w < 18; w++) begin
			mem[15][w / 17][w % 17 + w / 17] = 16'($urandom);
			if (w == 16)
				sndQ.push_back({4'hf, 1'b0, 16'h0020});
			eba_host_model_inst.access(1'b1, 1'b0, mem[15][w / 17][w % 17 + w / 17]);
		end
		sndQ.push_back({4'hf, 1'b1, 16'h0002});
		eba_host_model_inst.endPulse();
		peek(4'hf, 1'b1, 1);
		peek(4'hf, 1'b0, 16);
		eba_host_model_inst.setDma(1'b0);
		repeat (10) @(posedge clk);
		$display("test dma done");
		chk(rdQ.size() + clrQ.size() + sndQ.size(), 0);
		test_done();
	end
endmodule : eba_endpoint_buffer_access_bench
`default_nettype wire
